// File: fan_cmd_pkg.sv
// Constants, register map and types of the fan, sensor and live display
// command block. Assumes a 20 MHz clock and byte addressing on the bus.
package fan_cmd_pkg;
  localparam int CLK_NS = 50;
  localparam int EIGHTH_NS = 125_000_000;
  localparam int EIGHTH_CYCLES = EIGHTH_NS / CLK_NS;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_LEN = 8'h0c;
  localparam logic [7:0] OFS_RTYPE = 8'h10;
  localparam logic [7:0] OFS_RLEN = 8'h14;
  localparam logic [7:0] OFS_TMASK = 8'h18;
  localparam logic [7:0] OFS_FANS = 8'h1c;
  localparam logic [1:0] WIN_DATA = 2'h1;
  localparam logic [1:0] WIN_RDATA = 2'h2;
  localparam int CTRL_GO = 0;
  localparam int CTRL_STORE = 1;
  // Command types.
  localparam logic [7:0] CMD_FAN = 8'h11;
  localparam logic [7:0] CMD_IDQ = 8'h12;
  localparam logic [7:0] CMD_TEMP = 8'h13;
  localparam logic [7:0] CMD_XACT = 8'h14;
  localparam logic [7:0] CMD_LIVE = 8'h15;
  localparam logic [7:0] CMD_LCD = 8'h16;
  localparam logic [7:0] REPLY_FLAG = 8'h40;
  localparam logic [7:0] MATCH_ROM = 8'h55;
  localparam logic [7:0] FAN_FULL = 8'h64;
  localparam logic [7:0] SLOT_NONE = 8'h20;
  localparam logic [7:0] XACT_RD_MAX = 8'h0e;
  localparam logic [4:0] IDQ_RLEN = 5'h09;
  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_FAN = 2'h1;
  localparam logic [1:0] KIND_TEMP = 2'h2;
  localparam logic [1:0] MSG_VALUE = 2'h0;
  localparam logic [1:0] MSG_ERR = 2'h1;
  localparam logic [1:0] MSG_SLOW = 2'h2;
  localparam logic [7:0] FAN_RST = 8'h00;
  typedef enum logic [1:0] {
    OP_RESET, OP_WRITE, OP_READ, OP_ENUM
  } swbus_op_type;
  typedef struct packed {
    logic [1:0] kind;
    logic [4:0] sensor;
    logic [2:0] digits;
    logic [3:0] col;
    logic row;
    logic [5:0] extra;
  } slot_type;
  typedef struct packed {
    slot_type [7:0] slots;
    logic [3:0][7:0] fans;
  } boot_type;
endpackage : fan_cmd_pkg

// File: id_mem_if.sv
// Carrier between the command block and its identity memory.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface id_mem_if;
  logic we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport user (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : id_mem_if

// File: id_store.sv
// Identity memory: eight bytes for each sensor bus slot, registered read.
// Assumes write and read addresses are stable around the clock edge.
`timescale 1ns/10ps
module id_store #(
  parameter int DEPTH = 256
) (
  // Clock.
  input wire logic mclk,
  // Access port.
  id_mem_if.mem m
);
  logic [7:0] ram [DEPTH];
  logic [7:0] rdata_reg;

  if (DEPTH != 256) begin : g_depth_check
    $error("id_store depth must be 256");
  end

  always_ff @(posedge mclk) begin
    if (m.we) begin
      ram[m.waddr] <= m.wdata;
    end
    rdata_reg <= ram[m.raddr];
  end

  assign m.rdata = rdata_reg;
endmodule : id_store

// File: fan_sensor_live_display_commands.sv
// Command interpreter for fan power, sensor bus identities, temperature
// reports, bus transactions, live display slots and raw display commands.
// Assumes an external byte engine on the sensor bus and an external store.
// Operation
// - Fan power command: four bytes, levels 0 to 100, applied to fans.
// - Accepted command replies with type ORed with 0x40.
// - Store request saves current fan levels into boot image.
// - At power-up enumerate all bus devices and keep their identities.
// - Identity query: one slot byte 0-31, reply slot plus eight bytes.
// - Devices with a thermometer family code may report temperature.
// - Temperature command: 32-bit mask, reports every second.
// - Slot 32 skips addressing; else Match ROM then the identity.
// - Payload of two means no write phase; else writes size minus two.
// - Read count zero means no read; else reads that many into reply.
// - Eight live slots, configured with seven bytes or two for off.
// - Item kinds none, fan, temperature with sensor ranges 0-3, 0-31.
// - Digit counts and start column limits, row 0 or 1.
// - Last byte: pulses per turn 1-32 or temperature unit 0-1.
// - Show error text on CRC error, slow text on slow fans.
// - Shown fans forced full for one eighth of every half second.
// - Live slots update alone and belong to the boot image.
// - Raw command byte is forwarded to the display controller.
`timescale 1ns/10ps
module fan_sensor_live_display_commands
  import fan_cmd_pkg::*;
#(
  parameter int unsigned EIGHTH = EIGHTH_CYCLES,
  parameter logic [7:0] FAMILY_A = 8'ha1, // Value is arbitrary.
  parameter logic [7:0] FAMILY_B = 8'ha2  // Value is arbitrary.
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Avalon-MM slave.
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Sensor bus byte engine.
  output logic swbus_req,
  output swbus_op_type swbus_op,
  output logic [7:0] swbus_wdata,
  input wire logic swbus_done,
  input wire logic [7:0] swbus_rdata,
  input wire logic swbus_nodev,
  // Fans and sensors.
  output logic [3:0][7:0] fan_level,
  input wire logic [31:0] sens_crc_err,
  input wire logic [3:0] fan_slow,
  output logic temp_due,
  output logic [31:0] temp_mask,
  // Live display and raw controller access.
  output slot_type [7:0] live_slots,
  output logic [7:0][1:0] live_msg,
  output logic lcd_valid,
  output logic [7:0] lcd_byte,
  // Boot image store.
  input wire boot_type nv_image,
  output logic nv_save,
  output boot_type nv_image_out
);
  typedef enum logic [3:0] {
    ST_BOOT, ST_ENUM, ST_WAIT, ST_IDLE, ST_CHECK, ST_QFETCH, ST_QSTORE,
    ST_XNEXT, ST_XFETCH, ST_XSEND
  } state_type;

  typedef struct packed {
    state_type st;
    logic wait_b;
    logic [31:0] rdata;
    logic [7:0] cmd;
    logic [4:0] len;
    logic [15:0][7:0] data;
    logic [7:0] rtype;
    logic [4:0] rlen;
    logic [15:0][7:0] rbuf;
    logic busy;
    logic done;
    logic err;
    logic enum_done;
    logic [3:0][7:0] fans;
    logic [3:0][7:0] fan_out;
    slot_type [7:0] slots;
    logic [31:0] tmask;
    logic [31:0] present;
    logic [31:0] therm;
    logic [4:0] dev;
    logic [3:0] cnt;
    logic [3:0] acnt;
    logic [3:0] wcnt;
    logic [3:0] rcnt;
    logic addr_on;
    logic req;
    swbus_op_type op;
    logic [7:0] wdata;
    logic [31:0] div;
    logic [2:0] eighth_idx;
    logic temp_due;
    logic [31:0] tmask_out;
    logic [7:0][1:0] msg;
    logic nv_save;
    boot_type nv_out;
    logic lcd_valid;
    logic [7:0] lcd_byte;
  } core_type;

  core_type s;
  core_type n;
  id_mem_if m ();
  logic ok;
  logic [7:0] col_max;
  logic [3:0] am1;

  if (EIGHTH < 1) begin : g_eighth_check
    $error("EIGHTH must be at least one cycle");
  end

  id_store #(.DEPTH(256)) u_ids (.mclk(mclk), .m(m.mem));

  always_comb begin
    // Defaults: pulses drop, state holds.
    n = s;
    n.wait_b = 1'b1;
    n.req = 1'b0;
    n.temp_due = 1'b0;
    n.nv_save = 1'b0;
    n.lcd_valid = 1'b0;
    ok = 1'b0;
    col_max = 8'h0b;
    am1 = s.acnt - 4'h1;
    m.we = 1'b0;
    m.waddr = {s.dev, s.cnt[2:0]};
    m.wdata = swbus_rdata;
    m.raddr = {s.data[0][4:0], (s.st == ST_QFETCH) ? s.cnt[2:0] : am1[2:0]};

    // Bus slave: one wait cycle, then the access completes.
    if ((read || write) && s.wait_b) begin
      n.wait_b = 1'b0;
      n.rdata = 32'h0;
      case (address)
        OFS_STATUS: n.rdata = {28'h0, s.enum_done, s.err, s.done, s.busy};
        OFS_CMD: n.rdata = {24'h0, s.cmd};
        OFS_LEN: n.rdata = {27'h0, s.len};
        OFS_RTYPE: n.rdata = {24'h0, s.rtype};
        OFS_RLEN: n.rdata = {27'h0, s.rlen};
        OFS_TMASK: n.rdata = s.tmask;
        OFS_FANS: n.rdata = s.fans;
        default: begin
          if (address[7:6] == WIN_DATA) begin
            n.rdata = {24'h0, s.data[address[5:2]]};
          end else if (address[7:6] == WIN_RDATA) begin
            n.rdata = {24'h0, s.rbuf[address[5:2]]};
          end
        end
      endcase
    end
    if (write && !s.wait_b && byteenable[0]) begin
      case (address)
        OFS_CTRL: begin
          if (writedata[CTRL_GO] && !s.busy && s.enum_done) begin
            n.busy = 1'b1;
            n.done = 1'b0;
            n.err = 1'b0;
            n.st = ST_CHECK;
          end
          if (writedata[CTRL_STORE]) begin
            n.nv_save = 1'b1;
            n.nv_out = {s.slots, s.fans};
          end
        end
        OFS_CMD: if (!s.busy) n.cmd = writedata[7:0];
        OFS_LEN: if (!s.busy) n.len = writedata[4:0];
        default: begin
          if (address[7:6] == WIN_DATA && !s.busy) begin
            n.data[address[5:2]] = writedata[7:0];
          end
        end
      endcase
    end

    // Column limit by digit count.
    if (s.data[3] == 8'h03) begin
      col_max = 8'h0d;
    end else if (s.data[3] == 8'h04) begin
      col_max = 8'h0c;
    end

    case (s.st)
      ST_BOOT: begin
        n.fans = nv_image.fans;
        n.slots = nv_image.slots;
        n.st = ST_ENUM;
      end
      ST_ENUM: begin
        n.req = 1'b1;
        n.op = OP_ENUM;
        n.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (swbus_done && !s.enum_done) begin
          if (swbus_nodev) begin
            n.enum_done = 1'b1;
            n.st = ST_IDLE;
          end else begin
            m.we = 1'b1;
            if (s.cnt == 4'h0) begin
              n.present[s.dev] = 1'b1;
              n.therm[s.dev] = (swbus_rdata == FAMILY_A)
                || (swbus_rdata == FAMILY_B);
            end
            n.cnt = s.cnt + 4'h1;
            n.st = ST_ENUM;
            if (s.cnt == 4'h7) begin
              n.cnt = 4'h0;
              n.dev = s.dev + 5'h1;
              if (s.dev == 5'h1f) begin
                n.enum_done = 1'b1;
                n.st = ST_IDLE;
              end
            end
          end
        end else if (swbus_done) begin
          if (s.op == OP_READ) begin
            n.rbuf[s.rcnt] = swbus_rdata;
            n.rcnt = s.rcnt + 4'h1;
          end
          n.st = ST_XNEXT;
        end
      end
      ST_CHECK: begin
        case (s.cmd)
          CMD_FAN: ok = s.len == 5'h04 && s.data[0] <= FAN_FULL
            && s.data[1] <= FAN_FULL && s.data[2] <= FAN_FULL
            && s.data[3] <= FAN_FULL;
          CMD_IDQ: ok = s.len == 5'h01 && s.data[0] < SLOT_NONE;
          CMD_TEMP: ok = s.len == 5'h04;
          CMD_XACT: ok = s.len >= 5'h02 && s.len <= 5'h10
            && s.data[1] <= XACT_RD_MAX && (s.data[0] == SLOT_NONE
            || (s.data[0] < SLOT_NONE && s.present[s.data[0][4:0]]));
          CMD_LIVE: begin
            if (s.data[0] < 8'h08 && s.data[1] == {6'h0, KIND_NONE}) begin
              ok = s.len == 5'h02;
            end else if (s.data[0] < 8'h08 && s.len == 5'h07
                && s.data[4] <= col_max && s.data[5] <= 8'h01) begin
              if (s.data[1] == {6'h0, KIND_FAN}) begin
                ok = s.data[2] < 8'h04
                  && (s.data[3] == 8'h04 || s.data[3] == 8'h05)
                  && s.data[6] >= 8'h01 && s.data[6] <= 8'h20;
              end else if (s.data[1] == {6'h0, KIND_TEMP}) begin
                ok = s.data[2] < 8'h20 && s.present[s.data[2][4:0]]
                  && (s.data[3] == 8'h03 || s.data[3] == 8'h05)
                  && s.data[6] <= 8'h01;
              end
            end
          end
          CMD_LCD: ok = s.len == 5'h01;
          default: ok = 1'b0;
        endcase
        n.rtype = s.cmd | REPLY_FLAG;
        n.rlen = 5'h00;
        n.busy = 1'b0;
        n.done = 1'b1;
        n.st = ST_IDLE;
        if (!ok) begin
          n.err = 1'b1;
          n.rtype = 8'h00;
        end else begin
          case (s.cmd)
            CMD_FAN: n.fans = s.data[3:0];
            CMD_TEMP: n.tmask = {s.data[3], s.data[2], s.data[1], s.data[0]};
            CMD_LIVE: begin
              n.slots[s.data[0][2:0]] = '0;
              if (s.len == 5'h07) begin
                n.slots[s.data[0][2:0]] = {s.data[1][1:0], s.data[2][4:0],
                  s.data[3][2:0], s.data[4][3:0], s.data[5][0],
                  s.data[6][5:0]};
              end
            end
            CMD_LCD: begin
              n.lcd_valid = 1'b1;
              n.lcd_byte = s.data[0];
            end
            CMD_IDQ: begin
              n.busy = 1'b1;
              n.done = 1'b0;
              n.cnt = 4'h0;
              n.st = ST_QFETCH;
            end
            CMD_XACT: begin
              n.busy = 1'b1;
              n.done = 1'b0;
              n.acnt = 4'h0;
              n.wcnt = 4'h0;
              n.rcnt = 4'h0;
              n.addr_on = s.data[0] != SLOT_NONE;
              n.req = 1'b1;
              n.op = OP_RESET;
              n.st = ST_WAIT;
            end
            default: n.busy = 1'b0;
          endcase
        end
      end
      ST_QFETCH: n.st = ST_QSTORE;
      ST_QSTORE: begin
        n.rbuf[s.cnt + 4'h1] = m.rdata;
        n.cnt = s.cnt + 4'h1;
        n.st = ST_QFETCH;
        if (s.cnt == 4'h7) begin
          n.rbuf[0] = s.data[0];
          n.rlen = IDQ_RLEN;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.st = ST_IDLE;
        end
      end
      ST_XNEXT: begin
        n.st = ST_WAIT;
        if (s.addr_on && s.acnt == 4'h0) begin
          n.req = 1'b1;
          n.op = OP_WRITE;
          n.wdata = MATCH_ROM;
          n.acnt = 4'h1;
        end else if (s.addr_on && s.acnt < 4'h9) begin
          n.st = ST_XFETCH;
        end else if ({1'b0, s.wcnt} < s.len - 5'h02) begin
          n.req = 1'b1;
          n.op = OP_WRITE;
          n.wdata = s.data[s.wcnt + 4'h2];
          n.wcnt = s.wcnt + 4'h1;
        end else if ({4'h0, s.rcnt} < s.data[1]) begin
          n.req = 1'b1;
          n.op = OP_READ;
        end else begin
          n.rlen = {1'b0, s.rcnt};
          n.busy = 1'b0;
          n.done = 1'b1;
          n.st = ST_IDLE;
        end
      end
      ST_XFETCH: n.st = ST_XSEND;
      ST_XSEND: begin
        n.req = 1'b1;
        n.op = OP_WRITE;
        n.wdata = m.rdata;
        n.acnt = s.acnt + 4'h1;
        n.st = ST_WAIT;
      end
      ST_IDLE: begin
        // Stay, unless a GO from the bus section has moved on to the check.
      end
      default: n.st = ST_IDLE;
    endcase

    // Eighth-second divider: reports each second, fan override window.
    n.div = s.div + 32'h1;
    if (s.div >= EIGHTH - 1) begin
      n.div = 32'h0;
      n.eighth_idx = s.eighth_idx + 3'h1;
      if (s.eighth_idx == 3'h7) begin
        n.temp_due = 1'b1;
        n.tmask_out = s.tmask & s.therm & s.present;
      end
    end
    for (int f = 0; f < 4; f++) begin
      n.fan_out[f] = s.fans[f];
      for (int k = 0; k < 8; k++) begin
        if (s.slots[k].kind == KIND_FAN && s.slots[k].sensor == 5'(f)
            && s.eighth_idx[1:0] == 2'h0) begin
          n.fan_out[f] = FAN_FULL;
        end
      end
    end
    for (int k = 0; k < 8; k++) begin
      n.msg[k] = MSG_VALUE;
      if (s.slots[k].kind == KIND_TEMP
          && sens_crc_err[s.slots[k].sensor]) begin
        n.msg[k] = MSG_ERR;
      end else if (s.slots[k].kind == KIND_FAN
          && fan_slow[s.slots[k].sensor[1:0]]) begin
        n.msg[k] = MSG_SLOW;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.st <= ST_BOOT;
      s.wait_b <= 1'b1;
      s.fans <= {4{FAN_RST}};
      s.fan_out <= {4{FAN_RST}};
    end else begin
      s <= n;
    end
  end

  assign readdata = s.rdata;
  assign waitrequest = s.wait_b;
  assign swbus_req = s.req;
  assign swbus_op = s.op;
  assign swbus_wdata = s.wdata;
  assign fan_level = s.fan_out;
  assign temp_due = s.temp_due;
  assign temp_mask = s.tmask_out;
  assign live_slots = s.slots;
  assign live_msg = s.msg;
  assign lcd_valid = s.lcd_valid;
  assign lcd_byte = s.lcd_byte;
  assign nv_save = s.nv_save;
  assign nv_image_out = s.nv_out;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_WAIT_ONE: assert property ((read || write) && waitrequest
    |=> !waitrequest)
    else $error("waitrequest did not drop after one cycle");
  AST_FAN_RANGE: assert property (s.fans[0] <= FAN_FULL
    && s.fans[1] <= FAN_FULL && s.fans[2] <= FAN_FULL
    && s.fans[3] <= FAN_FULL)
    else $error("fan level above full power");
  AST_REPLY_TYPE: assert property ($rose(s.done) && !s.err
    |-> s.rtype == (s.cmd | REPLY_FLAG))
    else $error("reply type is not command ORed with 0x40");
  AST_ENUM_FIRST: assert property (s.st == ST_CHECK |-> s.enum_done)
    else $error("command taken before enumeration ended");
  AST_QUERY_LEN: assert property ($rose(s.done) && !s.err
    && s.cmd == CMD_IDQ |-> s.rlen == IDQ_RLEN && s.rbuf[0] == s.data[0])
    else $error("identity reply malformed");
  AST_ADDR_PHASE: assert property (swbus_req && swbus_wdata == MATCH_ROM
    && s.wcnt == 4'h0 && s.acnt == 4'h1 |-> s.addr_on)
    else $error("address phase issued for slot 32");
  AST_XACT_RLEN: assert property ($rose(s.done) && !s.err
    && s.cmd == CMD_XACT |-> s.rlen == s.data[1][4:0])
    else $error("read byte count differs from request");
  AST_REJECT: assert property (s.st == ST_CHECK && !ok
    |=> s.err && $stable(s.fans) && $stable(s.slots) && $stable(s.tmask))
    else $error("refused command changed state");
  AST_OVR_WINDOW: assert property (s.eighth_idx[1:0] != 2'h0
    |=> fan_level == $past(s.fans))
    else $error("fan override outside its window");
  for (genvar g = 0; g < 8; g++) begin : g_live
    AST_LIVE_ERR: assert property (@(posedge mclk) disable iff (!rst_b)
      s.slots[g].kind == KIND_TEMP && sens_crc_err[s.slots[g].sensor]
      |=> live_msg[g] == MSG_ERR)
      else $error("error text not shown on CRC error");
    COV_LIVE_FAN: cover property (@(posedge mclk) s.slots[g].kind == KIND_FAN);
  end
  AST_TEMP_GAP: assert property (temp_due |=> !temp_due [*2])
    else $error("temperature reports too close");

  COV_XACT_READ: cover property ($rose(s.done) && s.cmd == CMD_XACT
    && s.rlen != 5'h00);
  COV_QUERY: cover property ($rose(s.done) && s.cmd == CMD_IDQ && !s.err);
  COV_REJECT: cover property ($rose(s.err));
endmodule : fan_sensor_live_display_commands

// File: swbus_model.sv
// Sensor bus byte engine model with two devices; logs every non-enum op.
// Assumes one op at a time, held by the requester until done.
`timescale 1ns/10ps
module swbus_model
  import fan_cmd_pkg::*;
#(
  parameter logic [7:0] FAM = 8'ha1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Byte engine port.
  input wire logic swbus_req,
  input wire swbus_op_type swbus_op,
  input wire logic [7:0] swbus_wdata,
  output logic swbus_done,
  output logic [7:0] swbus_rdata,
  output logic swbus_nodev
);
  logic pend;
  logic [1:0] dly;
  logic [4:0] idx;
  logic [7:0] rdn;
  logic [9:0] ops [$];
  function automatic logic [7:0] idb(input int d, input int k);
    return (k == 0) ? ((d == 0) ? FAM : 8'h10) : 8'(8'h30 + 8 * d + k);
  endfunction : idb
  // Read data toggles when idle so a stale byte is never mistaken for data.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {pend, dly, idx, rdn, swbus_done, swbus_nodev} <= '0;
      swbus_rdata <= 8'h5a;
    end else begin
      swbus_done <= 1'b0;
      swbus_nodev <= 1'b0;
      swbus_rdata <= ~swbus_rdata;
      if (swbus_req) begin
        pend <= 1'b1;
        dly <= 2'h2;
        if (swbus_op != OP_ENUM) begin
          ops.push_back({swbus_op,
            (swbus_op == OP_WRITE) ? swbus_wdata : 8'h00});
        end
      end else if (pend && dly != 2'h0) begin
        dly <= dly - 2'h1;
      end else if (pend) begin
        pend <= 1'b0;
        swbus_done <= 1'b1;
        if (swbus_op == OP_READ) begin
          swbus_rdata <= 8'hc0 + rdn;
          rdn <= rdn + 8'h01;
        end else if (swbus_op == OP_ENUM) begin
          swbus_nodev <= (idx == 5'h10);
          swbus_rdata <= idb(idx[4:3], idx[2:0]);
          idx <= idx + 5'h01;
        end
      end
    end
  end
endmodule : swbus_model

// File: testbench.sv
// Testbench: drives the command block over Avalon-MM and checks replies.
// Assumes the sensor bus model and a 20 MHz clock.
`timescale 1ns/10ps
module testbench;
  import fan_cmd_pkg::*;
  localparam logic [7:0] FAM = 8'ha1;
  localparam slot_type TSLOT = '{KIND_TEMP, 5'h00, 3'h5, 4'hb, 1'b1, 6'h01};
  localparam slot_type FSLOT = '{KIND_FAN, 5'h01, 3'h4, 4'hc, 1'b0, 6'h20};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, temp_mask, rv, st, rt, rl;
  logic waitrequest, swbus_req, swbus_done, swbus_nodev;
  logic temp_due, lcd_valid, nv_save;
  swbus_op_type swbus_op;
  logic [7:0] swbus_wdata, swbus_rdata, lcd_byte, lcd_seen;
  logic [3:0][7:0] fan_level;
  logic [31:0] sens_crc_err = 32'h0;
  logic [3:0] fan_slow = 4'h0;
  slot_type [7:0] live_slots;
  logic [7:0][1:0] live_msg;
  boot_type nv_image = '{slots: '0, fans: 32'h0000000a};
  boot_type nv_image_out;
  int miscompares = 0;
  int tests_run = 0;
  int saves = 0;
  logic [7:0] pl [16];
  logic [9:0] exp_ops [$];
  logic [71:0] bad [7] = '{72'h11_04_00_65_00_00_00_00_00,
    72'h12_01_20_00_00_00_00_00_00, 72'h14_03_00_0f_00_00_00_00_00,
    72'h14_02_05_00_00_00_00_00_00, 72'h15_07_02_02_00_05_0c_00_00,
    72'h15_07_03_01_00_04_00_00_00, 72'h15_07_04_01_04_04_00_00_01};
  fan_sensor_live_display_commands #(.EIGHTH(4), .FAMILY_A(FAM)) i_dut (
    .mclk, .rst_b, .address, .read, .write, .byteenable(4'hf), .writedata,
    .readdata, .waitrequest, .swbus_req, .swbus_op, .swbus_wdata,
    .swbus_done, .swbus_rdata, .swbus_nodev, .fan_level, .sens_crc_err,
    .fan_slow, .temp_due, .temp_mask, .live_slots, .live_msg, .lcd_valid,
    .lcd_byte, .nv_image, .nv_save, .nv_image_out);
  swbus_model #(.FAM(FAM)) i_model (.mclk, .rst_b, .swbus_req, .swbus_op,
    .swbus_wdata, .swbus_done, .swbus_rdata, .swbus_nodev);
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    if (lcd_valid === 1'b1) lcd_seen <= lcd_byte;
    if (nv_save === 1'b1) saves <= saves + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    rv = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic set_pl(input logic [55:0] v);
    for (int i = 0; i < 7; i++) pl[i] = v[55 - 8 * i -: 8];
  endtask : set_pl
  task automatic cmd(input logic [7:0] c, input logic [7:0] n);
    int i;
    bus(1'b1, OFS_LEN, {24'h0, n});
    bus(1'b1, OFS_CMD, {24'h0, c});
    for (i = 0; i < n; i++) bus(1'b1, 8'(8'h40 + 4 * i), {24'h0, pl[i]});
    bus(1'b1, OFS_CTRL, 32'h1);
    repeat (3) @(posedge mclk);
    for (i = 0; i < 200; i++) begin
      bus(1'b0, OFS_STATUS, 32'h0);
      st = rv;
      if (st[1:0] === 2'b10) break;
    end
    bus(1'b0, OFS_RTYPE, 32'h0);
    rt = rv;
    bus(1'b0, OFS_RLEN, 32'h0);
    rl = rv;
  endtask : cmd
  task automatic reply(input logic [7:0] c, input logic [31:0] l);
    chk({28'h0, st[3:0]}, 32'ha, "status");
    chk(rt, {24'h0, c | REPLY_FLAG}, "reply type");
    chk(rl, l, "reply length");
  endtask : reply
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    close_out;
  end
  initial begin
    int i, j, k;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(fan_level, 32'h0000000a, "boot fans");
    st = 32'h0;
    for (i = 0; i < 300 && st[3] !== 1'b1; i++) begin
      bus(1'b0, OFS_STATUS, 32'h0);
      st = rv;
    end
    set_pl(56'h00_32_64_07_00_00_00);
    cmd(CMD_FAN, 8'h04);
    reply(CMD_FAN, 32'h0);
    chk(fan_level, 32'h07643200, "fan levels");
    bus(1'b0, OFS_FANS, 32'h0);
    chk(rv, 32'h07643200, "fans reg");
    $display("end fan power");
    for (k = 0; k < 7; k++) begin
      set_pl(bad[k][55:0]);
      cmd(bad[k][71:64], bad[k][63:56]);
      chk({28'h0, st[3:0]}, 32'he, "refused status");
      chk(rt, 32'h0, "refused type");
    end
    chk(fan_level, 32'h07643200, "fans kept");
    chk(live_slots[3], 32'h0, "slot kept");
    $display("end refusals");
    for (j = 0; j < 2; j++) begin
      pl[0] = 8'(j);
      cmd(CMD_IDQ, 8'h01);
      reply(CMD_IDQ, 32'h9);
      bus(1'b0, 8'h80, 32'h0);
      chk(rv, 32'(j), "id slot");
      for (k = 0; k < 8; k++) begin
        bus(1'b0, 8'(8'h84 + 4 * k), 32'h0);
        chk(rv, {24'h0, i_model.idb(j, k)}, "id byte");
      end
    end
    $display("end identity");
    set_pl(56'h01_00_00_00_00_00_00);
    cmd(CMD_TEMP, 8'h04);
    reply(CMD_TEMP, 32'h0);
    k = 0;
    repeat (64) begin
      @(posedge mclk);
      if (temp_due === 1'b1) begin
        k++;
        chk(temp_mask, 32'h1, "temp mask");
      end
    end
    chk(k, 32'h2, "temp reports");
    $display("end temp");
    set_pl(56'h00_02_a5_5a_00_00_00);
    i_model.ops.delete();
    cmd(CMD_XACT, 8'h04);
    reply(CMD_XACT, 32'h2);
    exp_ops = '{10'h000, 10'h155};
    for (k = 0; k < 8; k++) exp_ops.push_back({2'h1, i_model.idb(0, k)});
    exp_ops = {exp_ops, 10'h1a5, 10'h15a, 10'h200, 10'h200};
    chk(i_model.ops.size(), 32'he, "op count");
    for (k = 0; k < 14; k++) chk(i_model.ops[k], exp_ops[k], "op");
    bus(1'b0, 8'h80, 32'h0);
    chk(rv, 32'hc0, "read 0");
    bus(1'b0, 8'h84, 32'h0);
    chk(rv, 32'hc1, "read 1");
    set_pl(56'h20_00_00_00_00_00_00);
    i_model.ops.delete();
    cmd(CMD_XACT, 8'h02);
    reply(CMD_XACT, 32'h0);
    chk(i_model.ops.size(), 32'h1, "bare op count");
    chk(i_model.ops[0], 32'h0, "bare reset");
    $display("end transaction");
    set_pl(56'h02_02_00_05_0b_01_01);
    cmd(CMD_LIVE, 8'h07);
    reply(CMD_LIVE, 32'h0);
    chk(live_slots[2], TSLOT, "temp slot");
    set_pl(56'h03_01_01_04_0c_00_20);
    cmd(CMD_LIVE, 8'h07);
    reply(CMD_LIVE, 32'h0);
    chk(live_slots[3], FSLOT, "fan slot");
    sens_crc_err <= 32'h1;
    fan_slow <= 4'h2;
    repeat (40) @(posedge mclk);
    chk(live_msg[2], MSG_ERR, "error text");
    chk(live_msg[3], MSG_SLOW, "slow text");
    sens_crc_err <= 32'h0;
    fan_slow <= 4'h0;
    repeat (40) @(posedge mclk);
    chk(live_msg[3:2], {MSG_VALUE, MSG_VALUE}, "values");
    j = 0;
    k = 0;
    repeat (32) begin
      @(posedge mclk);
      if (fan_level[1] === FAN_FULL) k++;
      if (fan_level[1] === 8'h32) j++;
    end
    chk(k, 32'h8, "full cycles");
    chk(j, 32'h18, "set cycles");
    $display("end live");
    bus(1'b1, OFS_CTRL, 32'h2);
    repeat (4) @(posedge mclk);
    chk(saves, 32'h1, "save pulse");
    chk(nv_image_out.fans, 32'h07643200, "saved fans");
    chk(nv_image_out.slots[3], FSLOT, "saved slot");
    set_pl(56'h02_00_00_00_00_00_00);
    cmd(CMD_LIVE, 8'h02);
    reply(CMD_LIVE, 32'h0);
    chk(live_slots[2].kind, KIND_NONE, "slot off");
    set_pl(56'h38_00_00_00_00_00_00);
    cmd(CMD_LCD, 8'h01);
    reply(CMD_LCD, 32'h0);
    chk(lcd_seen, 32'h38, "raw byte");
    bus(1'b0, 8'hfc, 32'h0);
    chk(rv, 32'h0, "unmapped");
    $display("end store and raw");
    close_out;
  end
endmodule : testbench
